// [design/spi_cfg_device.sv]
// Device end of the serial configuration port with its register window.
// Assumes host drives sclk idle low, data changed on falling edges.
// Operation
// - Each transaction is exactly 24 clock periods.
// - First bit selects read or write direction.
// - Next 15 bits carry the register address.
// - Write frame: last eight bits stored.
// - Read frame: host drives first 16 bits.
// - 4-wire read data on dedicated output.
// - 3-wire read data on shared line.
// - Port selectable as 4-wire or 3-wire.
`timescale 1ns/1ns
module spi_cfg_device
   import spi_cfg_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  mode_3wire_i,
   spi_cfg_if.dev                     link,
   output logic                       wr_valid_o,
   output logic [ADDR_BITS-1:0]       wr_addr_o,
   output logic [DATA_BITS-1:0]       wr_data_o,
   output logic                       rd_valid_o,
   output logic [ADDR_BITS-1:0]       rd_addr_o,
   output logic                       frame_active_o
);

   // Link-clock domain
   logic                   frame_rst;
   logic                   mode_s1_r;
   logic                   mode_s2_r;
   logic [CNT_W-1:0]       bit_cnt_r;
   logic [HDR_BITS-1:0]    hdr_r;
   logic [DATA_BITS-1:0]   wdata_r;
   logic [DATA_BITS-1:0]   tx_r;
   logic [DATA_BITS-1:0]   regs_r [REG_DEPTH];
   logic [ADDR_BITS-1:0]   addr_full;
   logic [DATA_BITS-1:0]   wbyte_full;
   logic                   dir_now;
   logic                   hdr_last;
   logic                   frame_last;
   logic                   read_phase;
   logic                   wr_tog_r;
   logic                   rd_tog_r;
   logic [ADDR_BITS-1:0]   wr_addr_l_r;
   logic [DATA_BITS-1:0]   wr_data_l_r;
   logic [ADDR_BITS-1:0]   rd_addr_l_r;
   logic                   drive_r;
   logic                   out_r;

   // Core-clock domain
   logic [1:0]             tog_s1_r;
   logic [1:0]             tog_s2_r;
   logic [1:0]             tog_s3_r;
   logic                   cs_s1_r;
   logic                   cs_s2_r;
   logic [1:0]             tog_edge;

   // Deselect clears the frame at once, since sclk may never tick again
   assign frame_rst  = rst_i | link.cs_n;

   assign addr_full  = {hdr_r[ADDR_BITS-2:0], link.sdio};
   assign dir_now    = hdr_r[ADDR_BITS-1];
   assign wbyte_full = {wdata_r[DATA_BITS-2:0], link.sdio};
   assign hdr_last   = (bit_cnt_r == CNT_W'(HDR_BITS - 1));
   assign frame_last = (bit_cnt_r == CNT_W'(FRAME_BITS - 1));
   assign read_phase = (bit_cnt_r >= CNT_W'(HDR_BITS)) && (bit_cnt_r < CNT_W'(FRAME_BITS))
                       && (hdr_r[HDR_BITS-1] == DIR_READ);

   // Mode level comes from the core side, so it is resynchronised
   always_ff @(posedge link.sclk or posedge rst_i) begin
      if (rst_i) begin
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
      end else begin
         mode_s1_r <= mode_3wire_i;
         mode_s2_r <= mode_s1_r;
      end
   end

   // Bit counter saturates so extra clocks are ignored
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         bit_cnt_r <= '0;
      end else if (bit_cnt_r < CNT_W'(FRAME_BITS)) begin
         bit_cnt_r <= bit_cnt_r + CNT_W'(1);
      end
   end

   // Header shift, MSB first
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         hdr_r <= '0;
      end else if (bit_cnt_r < CNT_W'(HDR_BITS)) begin
         hdr_r <= {hdr_r[HDR_BITS-2:0], link.sdio};
      end
   end

   // Payload shift for write frames
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         wdata_r <= '0;
      end else if (bit_cnt_r >= CNT_W'(HDR_BITS) && bit_cnt_r < CNT_W'(FRAME_BITS)) begin
         wdata_r <= {wdata_r[DATA_BITS-2:0], link.sdio};
      end
   end

   // Read byte is fetched on the last header edge, half a period before use
   always_ff @(posedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         tx_r <= '0;
      end else if (hdr_last && dir_now == DIR_READ) begin
         if (addr_mapped(addr_full)) begin
            tx_r <= regs_r[addr_full[REG_IDX_W-1:0]];
         end else begin
            tx_r <= UNMAPPED_RDATA;
         end
      end else if (read_phase) begin
         tx_r <= {tx_r[DATA_BITS-2:0], 1'b0};
      end
   end

   // Storage and event latches survive deselect; only rst_i clears them
   always_ff @(posedge link.sclk or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < REG_DEPTH; i++) begin
            regs_r[i] <= REG_RESET_VAL;
         end
         wr_tog_r    <= 1'b0;
         wr_addr_l_r <= '0;
         wr_data_l_r <= '0;
      end else if (!link.cs_n && frame_last && hdr_r[HDR_BITS-1] == DIR_WRITE) begin
         if (addr_mapped(hdr_r[ADDR_BITS-1:0])) begin
            regs_r[hdr_r[REG_IDX_W-1:0]] <= wbyte_full;
         end
         wr_addr_l_r <= hdr_r[ADDR_BITS-1:0];
         wr_data_l_r <= wbyte_full;
         wr_tog_r    <= ~wr_tog_r;
      end
   end

   always_ff @(posedge link.sclk or posedge rst_i) begin
      if (rst_i) begin
         rd_tog_r    <= 1'b0;
         rd_addr_l_r <= '0;
      end else if (!link.cs_n && hdr_last && dir_now == DIR_READ) begin
         rd_addr_l_r <= addr_full;
         rd_tog_r    <= ~rd_tog_r;
      end
   end

   // Launch read bits on falling edges; host samples on rising
   always_ff @(negedge link.sclk or posedge frame_rst) begin
      if (frame_rst) begin
         drive_r <= 1'b0;
         out_r   <= 1'b0;
      end else begin
         drive_r <= read_phase;
         out_r   <= tx_r[DATA_BITS-1];
      end
   end

   // Gated by cs_n so the line is freed even if sclk stops early
   assign link.dev_sdio_o     = out_r;
   assign link.dev_sdio_oe    = drive_r & mode_s2_r & ~link.cs_n;
   assign link.serial_data_out = out_r & ~mode_s2_r;

   // Event toggles into the core clock; latched words hold a whole frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tog_s1_r <= '0;
         tog_s2_r <= '0;
         tog_s3_r <= '0;
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
      end else if (ce_i) begin
         tog_s1_r <= {rd_tog_r, wr_tog_r};
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         cs_s1_r  <= link.cs_n;
         cs_s2_r  <= cs_s1_r;
      end
   end

   assign tog_edge = tog_s2_r ^ tog_s3_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_valid_o <= 1'b0;
         wr_addr_o  <= '0;
         wr_data_o  <= '0;
      end else if (ce_i) begin
         wr_valid_o <= tog_edge[0];
         if (tog_edge[0]) begin
            wr_addr_o <= wr_addr_l_r;
            wr_data_o <= wr_data_l_r;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_valid_o <= 1'b0;
         rd_addr_o  <= '0;
      end else if (ce_i) begin
         rd_valid_o <= tog_edge[1];
         if (tog_edge[1]) begin
            rd_addr_o <= rd_addr_l_r;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_active_o <= 1'b0;
      end else if (ce_i) begin
         frame_active_o <= ~cs_s2_r;
      end
   end

endmodule

// [design/spi_cfg_host.sv]
// Host end of the configuration port: turns commands into 24-bit frames.
// Assumes a single command at a time; sclk is divided down from clk_i.
`timescale 1ns/1ns
module spi_cfg_host
   import spi_cfg_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  mode_3wire_i,
   input  wire logic                  cmd_valid_i,
   output logic                       cmd_ready_o,
   input  wire logic                  cmd_read_i,
   input  wire logic [ADDR_BITS-1:0]  cmd_addr_i,
   input  wire logic [DATA_BITS-1:0]  cmd_wdata_i,
   output logic                       rsp_valid_o,
   output logic [DATA_BITS-1:0]       rsp_rdata_o,
   spi_cfg_if.host                    link
);

   host_state_t            state_r;
   logic [HALF_W-1:0]      half_r;
   logic [CNT_W-1:0]       bit_r;
   logic [FRAME_BITS-1:0]  tx_r;
   logic                   rd_r;
   logic                   mode_r;
   logic                   sclk_r;
   logic                   cs_n_r;
   logic                   oe_r;
   logic                   sdio_s1_r;
   logic                   sdio_s2_r;
   logic                   sdo_s1_r;
   logic                   sdo_s2_r;
   logic                   rx_bit;
   logic                   half_done;

   assign cmd_ready_o = (state_r == H_IDLE);
   assign half_done   = (half_r == HALF_W'(SCLK_HALF_CYC - 1));
   assign rx_bit      = mode_r ? sdio_s2_r : sdo_s2_r;

   // Returned data arrives from the link, so two flops first
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sdio_s1_r <= 1'b0;
         sdio_s2_r <= 1'b0;
         sdo_s1_r  <= 1'b0;
         sdo_s2_r  <= 1'b0;
      end else if (ce_i) begin
         sdio_s1_r <= link.sdio;
         sdio_s2_r <= sdio_s1_r;
         sdo_s1_r  <= link.serial_data_out;
         sdo_s2_r  <= sdo_s1_r;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= H_IDLE;
         half_r      <= '0;
         bit_r       <= '0;
         tx_r        <= '0;
         rd_r        <= 1'b0;
         mode_r      <= 1'b0;
         sclk_r      <= 1'b0;
         cs_n_r      <= 1'b1;
         oe_r        <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= '0;
      end else if (ce_i) begin
         rsp_valid_o <= 1'b0;
         unique case (state_r)
            H_IDLE: begin
               if (cmd_valid_i) begin
                  tx_r        <= {cmd_read_i, cmd_addr_i, cmd_wdata_i};
                  rd_r        <= cmd_read_i;
                  mode_r      <= mode_3wire_i;
                  cs_n_r      <= 1'b0;
                  oe_r        <= 1'b1;
                  bit_r       <= '0;
                  half_r      <= '0;
                  rsp_rdata_o <= '0;
                  state_r     <= H_LOW;
               end
            end
            H_LOW: begin
               if (half_done) begin
                  half_r  <= '0;
                  sclk_r  <= 1'b1;
                  state_r <= H_HIGH;
                  if (rd_r && bit_r >= CNT_W'(HDR_BITS)) begin
                     rsp_rdata_o <= {rsp_rdata_o[DATA_BITS-2:0], rx_bit};
                  end
               end else begin
                  half_r <= half_r + HALF_W'(1);
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  half_r <= '0;
                  sclk_r <= 1'b0;
                  if (bit_r == CNT_W'(FRAME_BITS - 1)) begin
                     state_r <= H_DONE;
                  end else begin
                     bit_r   <= bit_r + CNT_W'(1);
                     tx_r    <= {tx_r[FRAME_BITS-2:0], 1'b0};
                     state_r <= H_LOW;
                     // Let go of the shared line before the first data bit
                     if (rd_r && mode_r && bit_r == CNT_W'(HDR_BITS - 1)) begin
                        oe_r <= 1'b0;
                     end
                  end
               end else begin
                  half_r <= half_r + HALF_W'(1);
               end
            end
            H_DONE: begin
               cs_n_r      <= 1'b1;
               oe_r        <= 1'b0;
               rsp_valid_o <= 1'b1;
               state_r     <= H_IDLE;
            end
         endcase
      end
   end

   assign link.sclk         = sclk_r;
   assign link.cs_n         = cs_n_r;
   assign link.host_sdio_o  = tx_r[FRAME_BITS-1];
   assign link.host_sdio_oe = oe_r;

endmodule

// [design/spi_cfg_if.sv]
// Link between host end and device end of the configuration port.
// The shared data line is resolved here from both enables, pulled high.
`timescale 1ns/1ns
interface spi_cfg_if;
   logic sclk;
   logic cs_n;
   logic host_sdio_o;
   logic host_sdio_oe;
   logic dev_sdio_o;
   logic dev_sdio_oe;
   logic serial_data_out;
   logic sdio;

   // Host wins a clash; neither end should ever let one happen
   assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

   modport host (
      output sclk,
      output cs_n,
      output host_sdio_o,
      output host_sdio_oe,
      input  sdio,
      input  serial_data_out
   );

   modport dev (
      input  sclk,
      input  cs_n,
      input  sdio,
      output dev_sdio_o,
      output dev_sdio_oe,
      output serial_data_out
   );
endinterface

// [design/spi_cfg_pkg.sv]
// Shared constants and types for the serial configuration port.
// Assumes both ends and the testbench import this package.
package spi_cfg_pkg;

   localparam int FRAME_BITS      = 24;
   localparam int HDR_BITS        = 16;
   localparam int ADDR_BITS       = 15;
   localparam int DATA_BITS       = 8;
   localparam int CNT_W           = 5;

   localparam logic DIR_READ      = 1'b1;
   localparam logic DIR_WRITE     = 1'b0;

   // Only a small window of the address space is backed by storage
   localparam int REG_DEPTH       = 16;
   localparam int REG_IDX_W       = 4;
   localparam logic [7:0] REG_RESET_VAL  = 8'h00;
   localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

   localparam int CLK_PERIOD_NS   = 10;
   localparam int SCLK_PERIOD_NS  = 80;
   localparam int SCLK_HALF_CYC   = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int HALF_W          = 3;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_LOW  = 2'b01,
      H_HIGH = 2'b10,
      H_DONE = 2'b11
   } host_state_t;

   function automatic logic addr_mapped(input logic [ADDR_BITS-1:0] addr);
      addr_mapped = (addr[ADDR_BITS-1:REG_IDX_W] == '0);
   endfunction

endpackage

// [tb/spi_cfg_properties.sv]
// Assertions on the link between the host end and the device end.
// Assumes one mode input feeds both ends and changes only between frames.
`timescale 1ns/1ns
module spi_cfg_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic mode_3wire_i,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_oe,
   input wire logic sdio
);
   logic [4:0] cnt_r;
   logic       sclk_q_r;
   logic       dir_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) sclk_q_r <= 1'b0;
      else sclk_q_r <= sclk;
   end

   // Rises counted in the core domain; sclk is slow enough to see each one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cnt_r <= 5'h00;
      else if (cs_n) cnt_r <= 5'h00;
      else if (sclk && !sclk_q_r) cnt_r <= cnt_r + 5'h01;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) dir_r <= 1'b0;
      else if (!cs_n && sclk && !sclk_q_r && cnt_r == 5'h00) dir_r <= sdio;
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_lead;
      (!sclk) [*4];
   endsequence
   sequence seq_high;
      sclk [*4];
   endsequence

   AST_FRAME_BITS: assert property ($rose(cs_n) |-> cnt_r == 5'h18)
      else $error("frame ended without 24 clock rises");
   AST_SCLK_HIGH: assert property ($rose(sclk) |-> seq_high ##1 !sclk)
      else $error("link clock high phase has the wrong length");
   AST_FRAME_START: assert property ($fell(cs_n) |-> seq_lead ##1 sclk)
      else $error("first clock rise not four cycles after select");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("link clock not low while deselected");
   AST_NO_CLASH: assert property (!(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive the shared line");
   AST_DEV_RELEASE: assert property (cs_n [*3] |-> !dev_sdio_oe)
      else $error("device drives the shared line while deselected");
   AST_DEV_END: assert property (cnt_r == 5'h18 && !sclk |-> !dev_sdio_oe)
      else $error("device still drives the shared line after the last bit");
   AST_HDR_DRIVEN: assert property (!cs_n && cnt_r < 5'h10 |-> host_sdio_oe)
      else $error("host not driving during the header");
   AST_4W_HOST: assert property (!mode_3wire_i && !cs_n |-> host_sdio_oe && !dev_sdio_oe)
      else $error("shared line turned round in four-wire mode");
   AST_3W_TURN: assert property (mode_3wire_i && dir_r && cnt_r > 5'h10 && cnt_r < 5'h18
                                 |-> !host_sdio_oe && dev_sdio_oe)
      else $error("three-wire read data not driven by the device");
endmodule

// [tb/testbench.sv]
// Self-checking bench: host end and device end joined by the link.
// Assumes one command at a time; expectations wait in queues.
`timescale 1ns/1ns
module testbench;
   import spi_cfg_pkg::*;
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   logic                 mode_r = 1'b0;
   logic                 cmd_valid = 1'b0;
   logic                 cmd_read = 1'b0;
   logic [ADDR_BITS-1:0] cmd_addr = '0;
   logic [DATA_BITS-1:0] cmd_wdata = '0;
   logic                 cmd_ready, rsp_valid, wr_valid, rd_valid;
   logic [DATA_BITS-1:0] rsp_rdata, wr_data;
   logic [ADDR_BITS-1:0] wr_addr, rd_addr;
   logic [7:0]           mem [16];
   logic [23:0]          rsp_q[$], wr_q[$], rd_q[$], fr_q[$];
   logic [23:0]          sh;
   logic [4:0]           bc;
   // Direction of the frame on the wire, caught at its first rise
   logic                 frd;
   logic                 frame_act;
   logic [31:0]          seed = 32'hd5bb78d7;
   int                   bad_count = 0;
   int                   checked = 0;

   always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

   spi_cfg_if link ();
   spi_cfg_host spi_cfg_host_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .mode_3wire_i(mode_r),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_addr_i(cmd_addr),
      .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .link(link.host));
   spi_cfg_device spi_cfg_device_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .mode_3wire_i(mode_r),
      .link(link.dev), .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .rd_valid_o(rd_valid), .rd_addr_o(rd_addr), .frame_active_o(frame_act));
   spi_cfg_properties spi_cfg_properties_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_3wire_i(mode_r),
      .sclk(link.sclk), .cs_n(link.cs_n), .host_sdio_oe(link.host_sdio_oe),
      .dev_sdio_oe(link.dev_sdio_oe), .sdio(link.sdio));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Bounded wait for an idle host, optionally with response and frame notes consumed
   task automatic wait_idle(input bit drain);
      int n = 0;
      do begin
         @(negedge clk_i);
         n++;
         if (n > 500) begin
            bad_count++;
            complete_run();
         end
      end while (!(cmd_ready === 1'b1 && (!drain || rsp_q.size() + fr_q.size() == 0)));
      @(posedge clk_i);
   endtask

   task automatic send(input logic rd, input logic [14:0] a, input logic [7:0] d);
      logic [7:0] e;
      e = (rd && a[14:4] == 11'h000) ? mem[a[3:0]] : 8'h00;
      if (!rd && a[14:4] == 11'h000) mem[a[3:0]] = d;
      wait_idle(1'b0);
      rsp_q.push_back(24'(e));
      fr_q.push_back({rd, a, rd ? e : d});
      if (rd) rd_q.push_back(24'(a));
      else wr_q.push_back({1'b0, a, d});
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_read <= rd;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk_i);
      cmd_valid <= 1'b0;
   endtask

   always @(posedge clk_i) begin
      if (rsp_valid === 1'b1) check(24'(rsp_rdata), rsp_q.size() ? rsp_q.pop_front() : 24'hffffff);
      if (wr_valid === 1'b1) check({1'b0, wr_addr, wr_data}, wr_q.size() ? wr_q.pop_front() : 24'hffffff);
      if (rd_valid === 1'b1) check(24'(rd_addr), rd_q.size() ? rd_q.pop_front() : 24'hffffff);
   end

   // Wire view: four-wire read data taken from the dedicated output
   always @(negedge link.cs_n) bc = 5'h00;
   always @(posedge link.sclk) begin
      if (link.cs_n === 1'b0) begin
         if (bc == 5'h00) frd = link.sdio;
         sh = {sh[22:0], (bc >= 5'h10 && frd && !mode_r) ? link.serial_data_out : link.sdio};
         bc++;
      end
   end
   always @(posedge link.cs_n) begin
      if (!rst_i) begin
         check(24'(bc), 24'h000018);
         check(sh, fr_q.size() ? fr_q.pop_front() : 24'hffffff);
         check(24'(frame_act), 24'h000001);
      end
   end

   initial begin
      int i;
      int p;
      logic [14:0] a;
      mem = '{default: REG_RESET_VAL};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      send(1'b1, 15'h0000, 8'h00);
      for (p = 0; p < 2; p++) begin
         for (i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            // About a quarter of the addresses fall outside the window
            a = {seed[31:21] & {11{seed[9] & seed[10]}}, seed[3:0]};
            send(seed[20], a, seed[18:11]);
         end
         for (i = 0; i < 16; i++) send(1'b1, 15'(i), seed[7:0]);
         wait_idle(1'b1);
         mode_r <= ~mode_r;
         // Write frame gives the device time to take up the new mode
         send(1'b0, 15'h7fff, seed[15:8]);
      end
      wait_idle(1'b1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      mem = '{default: REG_RESET_VAL};
      send(1'b1, 15'h0000, 8'h00);
      send(1'b1, 15'h000f, 8'h00);
      wait_idle(1'b1);
      // Device events trail the frame; let them land before the tally
      repeat (4) @(posedge clk_i);
      check(24'(frame_act), 24'h000000);
      check(24'(wr_q.size() + rd_q.size() + rsp_q.size() + fr_q.size()), 24'h000000);
      complete_run();
   end
endmodule
